/* src/arp_top.sv */
// averaging, offset/gain correction and threshold alerts for multiplexed conversion results
`timescale 1ns/100ps
`include "arp_map.svh"
module arp_top
  import arp_pkg::*;
#(
  parameter int NCH = 16,
  parameter int DW = 16
) (
  input wire logic clk_sys, // core clock
  input wire logic rst, // async reset, high
  input wire logic [`ARP_AW-1:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, next cycle
  input wire logic conversion_start, // external trigger pulse
  input wire logic auto_trig, // internal autocycle trigger
  input wire logic [3:0] seq_chan, // channel asked by sequencer
  output logic [3:0] mux_chan, // channel the mux selects
  output logic mux_hold, // averaging in progress
  input wire logic conv_valid, // core result pulse
  input wire logic [DW-1:0] conv_data, // core result
  output logic busy, // data-not-ready
  output logic [18:0] res_out, // corrected result
  output logic [3:0] res_chan, // its channel
  output logic res_valid, // result pulse
  output logic summary_threshold_alert // OR of all flags
);
  generate
    if (NCH != 16 || DW != 16) begin : g_chk
      $error("arp_top serves 16 channels of 16 bits only");
    end
  endgenerate

  logic [3:0] channel_config_reg [NCH];
  logic [15:0] channel_gain_reg [NCH];
  logic [15:0] channel_offset_reg [NCH];
  logic [11:0] channel_upper_limit_reg [NCH];
  logic [11:0] channel_lower_limit_reg [NCH];
  logic [11:0] channel_hyst_reg [NCH];
  logic [3:0] setup_reg;
  logic [NCH-1:0] channel_high_alert_flag;
  logic [NCH-1:0] channel_low_alert_flag;

  arp_seq_e seq_mode;
  logic alert_mode;
  logic autocycle;
  assign seq_mode = arp_seq_e'(setup_reg[`ARP_SET_SEQ_LSB +: 2]);
  assign alert_mode = setup_reg[`ARP_SET_AMODE_BIT];
  assign autocycle = setup_reg[`ARP_SET_AUTO_BIT];

  // register writes
  logic [3:0] wch;
  logic [2:0] wgrp;
  assign wch = reg_addr[3:0];
  assign wgrp = reg_addr[6:4];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        channel_config_reg[i] <= 4'h0;
        channel_gain_reg[i] <= `ARP_RST_GAIN;
        channel_offset_reg[i] <= 16'h0000;
        channel_upper_limit_reg[i] <= `ARP_RST_UPR;
        channel_lower_limit_reg[i] <= `ARP_RST_LWR;
        channel_hyst_reg[i] <= `ARP_RST_HYS;
      end
    end else if (reg_wr) begin
      unique case (wgrp)
        3'h0: channel_config_reg[wch] <= reg_wdata[3:0];
        3'h1: channel_gain_reg[wch] <= reg_wdata;
        3'h2: channel_offset_reg[wch] <= reg_wdata;
        3'h3: channel_upper_limit_reg[wch] <= reg_wdata[11:0];
        3'h4: channel_lower_limit_reg[wch] <= reg_wdata[11:0];
        3'h5: channel_hyst_reg[wch] <= reg_wdata[11:0];
        default: ;
      endcase
    end
  end

  // alert mode resets to 0 so hysteresis clearing is the default
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      setup_reg <= 4'h0;
    end else if (reg_wr && reg_addr == `ARP_OFS_SETUP) begin
      setup_reg <= reg_wdata[3:0];
    end
  end

  // per-channel settings as seen through the sequencer mode
  function automatic arp_osr_t osr_of(input logic [3:0] ch);
    // in command modes the host keeps the field at zero
    if (seq_mode == ARP_SEQ_STD)
      return channel_config_reg[0][`ARP_CFG_OSR_LSB +: 2];
    return channel_config_reg[ch][`ARP_CFG_OSR_LSB +: 2];
  endfunction

  function automatic logic [5:0] last_of(input arp_osr_t o);
    unique case (o)
      2'h0: return 6'h00;
      2'h1: return 6'h03;
      2'h2: return 6'h0F;
      2'h3: return 6'h3F;
    endcase
  endfunction

  // conversion trigger and busy
  logic trig;
  logic [5:0] cnt;
  logic [3:0] cur_chan;
  arp_osr_t cur_osr;
  logic cur_bip;
  logic [21:0] acc;
  logic [21:0] samp_ext;
  logic last_samp;
  logic avg_valid;
  logic [21:0] avg;
  logic [3:0] avg_chan;
  arp_osr_t avg_osr;
  logic avg_bip;
  logic samp_bip;
  logic [21:0] acc_next;

  // the same count applies whichever source fires the conversions
  assign trig = autocycle ? auto_trig : conversion_start;
  assign mux_hold = (cnt != 6'h00);
  assign mux_chan = mux_hold ? cur_chan : seq_chan;
  // a process, not an assign, so the config registers read inside osr_of wake it
  always_comb begin
    last_samp = conv_valid && (cnt == last_of(mux_hold ? cur_osr : osr_of(seq_chan)));
  end

  always_comb begin
    samp_bip = mux_hold ? cur_bip : channel_config_reg[seq_chan][`ARP_CFG_BIP_BIT];
    samp_ext = samp_bip ? {{6{conv_data[DW-1]}}, conv_data} : {6'h00, conv_data};
  end
  assign acc_next = (mux_hold ? acc : 22'h000000) + samp_ext;

  // busy falls with the averaged result, not per conversion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (trig) begin
      busy <= 1'b1;
    end else if (res_valid) begin
      busy <= 1'b0;
    end
  end

  // channel stays selected until the ratio is met
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 6'h00;
      cur_chan <= 4'h0;
      cur_osr <= 2'h0;
      cur_bip <= 1'b0;
    end else if (conv_valid) begin
      if (!mux_hold) begin
        cur_chan <= seq_chan;
        cur_osr <= osr_of(seq_chan);
        cur_bip <= channel_config_reg[seq_chan][`ARP_CFG_BIP_BIT];
      end
      cnt <= last_samp ? 6'h00 : cnt + 6'h01;
    end
  end

  // accumulate, then keep one extra bit per factor of four
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc <= 22'h000000;
      avg <= 22'h000000;
      avg_valid <= 1'b0;
      avg_chan <= 4'h0;
      avg_osr <= 2'h0;
      avg_bip <= 1'b0;
    end else begin
      avg_valid <= last_samp;
      if (conv_valid) begin
        acc <= acc_next;
      end
      if (last_samp) begin
        // unipolar sums of 64 reach bit 21, so only bipolar sums may shift in a sign
        if (samp_bip) begin
          avg <= $signed(acc_next) >>> (mux_hold ? cur_osr : 2'h0);
        end else begin
          avg <= acc_next >> (mux_hold ? cur_osr : 2'h0);
        end
        avg_chan <= mux_chan;
        avg_osr <= mux_hold ? cur_osr : osr_of(seq_chan);
        avg_bip <= mux_hold ? cur_bip : channel_config_reg[seq_chan][`ARP_CFG_BIP_BIT];
      end
    end
  end

  // offset and gain correction, always active
  logic signed [21:0] ofs_al;
  logic signed [21:0] sum_c;
  logic signed [38:0] prod;
  logic signed [23:0] scaled;
  logic signed [21:0] corr;

  always_comb begin
    logic signed [23:0] hi_lim;
    logic signed [23:0] lo_lim;
    hi_lim = 24'sh0;
    lo_lim = 24'sh0;
    // offset top bit sits at result MSB-3 for every ratio
    ofs_al = 22'($signed(channel_offset_reg[avg_chan])) >>> (2'h3 - avg_osr);
    sum_c = $signed(avg) + ofs_al;
    // gain over 2^15: 0x8000 is exactly one
    prod = sum_c * $signed({1'b0, channel_gain_reg[avg_chan]});
    scaled = prod[38:15];
    // saturate to the width the ratio calls for
    if (avg_bip) begin
      hi_lim = (24'sh1 <<< (5'd15 + 5'(avg_osr))) - 24'sh1;
      lo_lim = -(24'sh1 <<< (5'd15 + 5'(avg_osr)));
    end else begin
      hi_lim = (24'sh1 <<< (5'd16 + 5'(avg_osr))) - 24'sh1;
      lo_lim = 24'sh0;
    end
    if (scaled > hi_lim) begin
      corr = hi_lim[21:0];
    end else if (scaled < lo_lim) begin
      corr = lo_lim[21:0];
    end else begin
      corr = scaled[21:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      res_out <= 19'h00000;
      res_chan <= 4'h0;
      res_valid <= 1'b0;
    end else begin
      res_valid <= avg_valid;
      if (avg_valid) begin
        res_out <= corr[18:0];
        res_chan <= avg_chan;
      end
    end
  end

  // threshold compare on the 12 most significant result bits
  logic signed [13:0] top12;
  logic signed [13:0] upr;
  logic signed [13:0] lwr;
  logic signed [13:0] hys;
  logic td_on;
  logic hit_hi;
  logic hit_lo;
  logic rel_hi;
  logic rel_lo;

  always_comb begin
    logic signed [21:0] sh;
    sh = corr >>> (3'd4 + 3'(avg_osr));
    top12 = sh[13:0];
    if (avg_bip) begin
      upr = 14'($signed(channel_upper_limit_reg[avg_chan]));
      lwr = 14'($signed(channel_lower_limit_reg[avg_chan]));
    end else begin
      upr = {2'h0, channel_upper_limit_reg[avg_chan]};
      lwr = {2'h0, channel_lower_limit_reg[avg_chan]};
    end
    hys = {2'h0, channel_hyst_reg[avg_chan]};
    td_on = (seq_mode == ARP_SEQ_STD) ? channel_config_reg[0][`ARP_CFG_TDEN_BIT] :
            channel_config_reg[avg_chan][`ARP_CFG_TDEN_BIT];
    // evaluated only when the averaged result exists
    hit_hi = avg_valid && td_on && (top12 >= upr);
    hit_lo = avg_valid && td_on && (top12 <= lwr);
    rel_hi = avg_valid && td_on && !alert_mode && (top12 < upr - hys);
    rel_lo = avg_valid && td_on && !alert_mode && (top12 > lwr + hys);
  end

  // flags clear a cycle after the read that returned them; a new hit wins
  logic rd_hi;
  logic rd_lo;
  assign rd_hi = reg_rd && reg_addr == `ARP_OFS_ALERT_HI;
  assign rd_lo = reg_rd && reg_addr == `ARP_OFS_ALERT_LO;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_flag
      logic sel;
      assign sel = (avg_chan == 4'(g));
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          channel_high_alert_flag[g] <= 1'b0;
        end else if (sel && hit_hi) begin
          channel_high_alert_flag[g] <= 1'b1;
        end else if (rd_hi || (sel && rel_hi)) begin
          channel_high_alert_flag[g] <= 1'b0;
        end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          channel_low_alert_flag[g] <= 1'b0;
        end else if (sel && hit_lo) begin
          channel_low_alert_flag[g] <= 1'b1;
        end else if (rd_lo || (sel && rel_lo)) begin
          channel_low_alert_flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign summary_threshold_alert = |{channel_high_alert_flag, channel_low_alert_flag};

  // read port; the host is expected to be in configuration mode here
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (wgrp)
        3'h0: reg_rdata <= {12'h000, channel_config_reg[wch]};
        3'h1: reg_rdata <= channel_gain_reg[wch];
        3'h2: reg_rdata <= channel_offset_reg[wch];
        3'h3: reg_rdata <= {4'h0, channel_upper_limit_reg[wch]};
        3'h4: reg_rdata <= {4'h0, channel_lower_limit_reg[wch]};
        3'h5: reg_rdata <= {4'h0, channel_hyst_reg[wch]};
        3'h6: begin
          unique case (reg_addr)
            `ARP_OFS_SETUP: reg_rdata <= {12'h000, setup_reg};
            `ARP_OFS_STATUS: reg_rdata <= {14'h0000, busy, summary_threshold_alert};
            `ARP_OFS_ALERT_HI: reg_rdata <= channel_high_alert_flag;
            `ARP_OFS_ALERT_LO: reg_rdata <= channel_low_alert_flag;
            default: reg_rdata <= 16'h0000;
          endcase
        end
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

/* pkg/arp_map.svh */
// register offsets, field positions and reset values of the result post-processing path
// Operation
// - ratios 1, 4, 16, 64; ratio 1 passes through
// - ratios 4/16/64 give 17/18/19-bit results
// - hold channel until all conversions averaged
// - busy falls only with the averaged result
// - standard sequencer uses channel 0 ratio
// - autonomous triggers still need full ratio
// - output equals (average plus offset) times gain
// - gain is unsigned field over 2^15
// - offset top bit aligns result MSB-3
// - correction always on; neutral 0x0000/0x8000
// - threshold enable per channel, std uses ch0
// - 12-bit limits against result's 12 MSBs
// - limits unsigned unipolar, signed pseudobipolar
// - high flag set when result >= upper
// - low flag set when result <= lower
// - summary alert is OR of all flags
// - flags set and hyst-clear only on averaged results
// - flags clear after being read
// - alert mode 0 adds hysteresis clearing
// - clear below upper-hyst, above lower+hyst
`ifndef ARP_MAP_SVH
`define ARP_MAP_SVH
`define ARP_AW 7
`define ARP_BASE_CFG 7'h00
`define ARP_BASE_GAIN 7'h10
`define ARP_BASE_OFS 7'h20
`define ARP_BASE_UPR 7'h30
`define ARP_BASE_LWR 7'h40
`define ARP_BASE_HYS 7'h50
`define ARP_OFS_SETUP 7'h60
`define ARP_OFS_STATUS 7'h61
`define ARP_OFS_ALERT_HI 7'h62
`define ARP_OFS_ALERT_LO 7'h63
`define ARP_CFG_OSR_LSB 0
`define ARP_CFG_TDEN_BIT 2
`define ARP_CFG_BIP_BIT 3
`define ARP_SET_SEQ_LSB 0
`define ARP_SET_AMODE_BIT 2
`define ARP_SET_AUTO_BIT 3
`define ARP_RST_GAIN 16'h8000
`define ARP_RST_UPR 12'hFFF
`define ARP_RST_LWR 12'h000
`define ARP_RST_HYS 12'h000
`endif

/* pkg/arp_pkg.sv */
// types of the result post-processing path
package arp_pkg;
  typedef enum logic [1:0] {
    ARP_SEQ_STD = 2'h0,
    ARP_SEQ_ADV = 2'h1,
    ARP_SEQ_CMD2 = 2'h2,
    ARP_SEQ_CMD1 = 2'h3
  } arp_seq_e;
  typedef logic [1:0] arp_osr_t;
endpackage

/* bench/arp_core_model.sv */
// converter core stand-in: returns the staged sample two cycles after each trigger
`timescale 1ns/100ps
module arp_core_model (
  input wire logic clk_sys, // core clock
  input wire logic rst, // async reset, high
  input wire logic trig, // conversion trigger
  input wire logic [15:0] sample, // value the next conversion returns
  output logic conv_valid, // result pulse
  output logic [15:0] conv_data // result, scrambled outside the pulse
);
  logic armed;
  logic [15:0] held;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
      held <= 16'h0000;
      conv_valid <= 1'b0;
      conv_data <= 16'h0000;
    end else begin
      armed <= trig;
      if (trig) begin
        held <= sample;
      end
      conv_valid <= armed;
      // data lines are not held outside the pulse, so a late sampler sees garbage
      conv_data <= armed ? held : ~conv_data;
    end
  end
endmodule

/* bench/arp_top_sva.sv */
// port-level assertions for the post-processing path
`timescale 1ns/100ps
module arp_top_sva #(
  parameter int NCH = 16,
  parameter int DW = 16
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_rdata, // read data
  input wire logic conversion_start, // trigger
  input wire logic auto_trig, // internal trigger
  input wire logic [3:0] seq_chan, // asked channel
  input wire logic [3:0] mux_chan, // mux channel
  input wire logic mux_hold, // averaging
  input wire logic conv_valid, // core result
  input wire logic busy, // not ready
  input wire logic res_valid, // result pulse
  input wire logic summary_threshold_alert // any flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_done;
    res_valid && !conversion_start && !auto_trig;
  endsequence
  sequence s_idle_after;
    !busy;
  endsequence
  property p_res_cause;
    res_valid |-> $past(conv_valid, 2);
  endproperty
  a_res_cause: assert property (p_res_cause) else $error("result without sample two cycles before");
  property p_busy_clr;
    s_done |=> s_idle_after;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy still high after result");
  property p_busy_fall;
    $fell(busy) |-> $past(res_valid);
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell without a result");
  property p_hold;
    mux_hold && $past(mux_hold) |-> $stable(mux_chan);
  endproperty
  a_hold: assert property (p_hold) else $error("mux moved during averaging");
  property p_follow;
    !mux_hold |-> mux_chan == seq_chan;
  endproperty
  a_follow: assert property (p_follow) else $error("mux ignores sequencer");
  property p_alert_set;
    $rose(summary_threshold_alert) |-> res_valid;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert rose without result");
  property p_alert_clr;
    $fell(summary_threshold_alert) |-> $past(reg_rd) || $past(reg_rd, 2) || res_valid;
  endproperty
  a_alert_clr: assert property (p_alert_clr) else $error("alert cleared without read or result");
  property p_rd_quiet;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
endmodule
bind arp_top arp_top_sva #(.NCH(NCH), .DW(DW)) u_arp_top_sva (.clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conversion_start(conversion_start), .auto_trig(auto_trig), .seq_chan(seq_chan),
  .mux_chan(mux_chan), .mux_hold(mux_hold), .conv_valid(conv_valid), .busy(busy), .res_valid(res_valid),
  .summary_threshold_alert(summary_threshold_alert));

/* bench/tb_adc_result_postprocess.sv */
// self-checking bench for the post-processing path
`timescale 1ns/100ps
module tb_adc_result_postprocess;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] smp = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, conversion_start = 1'b0, auto_trig = 1'b0, auto_m = 1'b0;
  logic [3:0] seq_chan = 4'h0;
  logic [3:0] mux_chan, res_chan;
  logic [15:0] reg_rdata, conv_data;
  logic mux_hold, conv_valid, busy, res_valid, alert;
  logic [18:0] res_out;
  logic [22:0] expq[$];
  logic [15:0] gn[16], ofs[16];
  integer fail_count = 0, checked = 0, seed = 32'h6A3F;
  always #2 clk_sys = ~clk_sys;
  arp_top u_arp_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conversion_start(conversion_start), .auto_trig(auto_trig),
    .seq_chan(seq_chan), .mux_chan(mux_chan), .mux_hold(mux_hold), .conv_valid(conv_valid), .conv_data(conv_data),
    .busy(busy), .res_out(res_out), .res_chan(res_chan), .res_valid(res_valid), .summary_threshold_alert(alert));
  arp_core_model u_arp_core_model (.clk_sys(clk_sys), .rst(rst), .trig(conversion_start | auto_trig),
    .sample(smp), .conv_valid(conv_valid), .conv_data(conv_data));
  task chk_res(input logic [22:0] got, input logic [22:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t result %h expected %h", $time, got, exp);
    end
  endtask
  task chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a[6:4] == 3'h1) gn[a[3:0]] = d;
    if (a[6:4] == 3'h2) ofs[a[3:0]] = d;
  endtask
  task rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk_reg(reg_rdata, exp);
  endtask
  task cv(input logic [15:0] d);
    @(posedge clk_sys);
    smp <= d;
    conversion_start <= !auto_m;
    auto_trig <= auto_m;
    @(posedge clk_sys);
    conversion_start <= 1'b0;
    auto_trig <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  // saturating reference of (average + scaled offset) * gain
  function automatic logic [18:0] exp_out(longint s, int o, int ch, bit b);
    longint v, mx, mn;
    v = (s >>> o) + ($signed(ofs[ch]) >>> (3 - o));
    v = (v * longint'(gn[ch])) >>> 15;
    mx = (longint'(1) << (16 + o - b)) - 1;
    mn = b ? -mx - 1 : 0;
    if (v > mx) v = mx;
    if (v < mn) v = mn;
    return 19'(v);
  endfunction
  task avg(input int ch, input int o, input bit b, input bit rnd, input logic [15:0] fx);
    longint sum;
    logic [15:0] d;
    sum = 0;
    @(posedge clk_sys);
    seq_chan <= 4'(ch);
    for (int k = 0; k < (1 << (2 * o)); k++) begin
      d = rnd ? 16'($random(seed)) : fx;
      sum += b ? longint'($signed(d)) : longint'(d);
      if (k == (1 << (2 * o)) - 1) expq.push_back({4'(ch), exp_out(sum, o, ch, b)});
      cv(d);
      chk_reg({15'h0000, busy}, {15'h0000, k != (1 << (2 * o)) - 1});
      // a new request mid-average must not move the mux
      if (k == 0 && o > 0) begin
        @(posedge clk_sys);
        seq_chan <= 4'(ch + 1);
      end
    end
  endtask
  always @(negedge clk_sys) begin
    if (res_valid === 1'b1) chk_res({res_chan, res_out}, expq.size() > 0 ? expq.pop_front() : 23'h7FFFFF);
  end
  task final_report;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    final_report;
  end
  initial begin
    foreach (gn[i]) begin
      gn[i] = 16'h8000;
      ofs[i] = 16'h0000;
    end
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(7'h11, 16'h8000);
    rd(7'h32, 16'h0FFF);
    rd(7'h7F, 16'h0000);
    for (int o = 0; o < 4; o++) begin
      auto_m = (o == 3);
      wr(7'h60, {12'h000, auto_m, 3'h0});
      wr(7'h00, 16'(o));
      wr(7'h05 + 7'(o), {12'h000, o[0] ^ o[1], 3'h0});
      if (o != 0) wr(7'h15 + 7'(o), 16'($random(seed)));
      if (o != 0) wr(7'h25 + 7'(o), 16'($random(seed)));
      avg(5 + o, o, o[0] ^ o[1], 1'b1, 16'h0000);
    end
    auto_m = 1'b0;
    wr(7'h60, 16'h0001);
    wr(7'h09, 16'h0001);
    avg(9, 1, 1'b0, 1'b1, 16'h0000);
    wr(7'h60, 16'h0002);
    wr(7'h0A, 16'h0000);
    avg(10, 0, 1'b0, 1'b1, 16'h0000);
    wr(7'h60, 16'h0000);
    wr(7'h00, 16'h0004);
    wr(7'h33, 16'h0800);
    wr(7'h43, 16'h0100);
    wr(7'h53, 16'h0010);
    avg(3, 0, 1'b0, 1'b0, 16'h9000);
    chk_reg({15'h0000, alert}, 16'h0001);
    rd(7'h62, 16'h0008);
    rd(7'h62, 16'h0000);
    avg(3, 0, 1'b0, 1'b0, 16'h0500);
    rd(7'h63, 16'h0008);
    avg(3, 0, 1'b0, 1'b0, 16'h9000);
    avg(3, 0, 1'b0, 1'b0, 16'h7F00);
    chk_reg({15'h0000, alert}, 16'h0001);
    avg(3, 0, 1'b0, 1'b0, 16'h7E00);
    chk_reg({15'h0000, alert}, 16'h0000);
    wr(7'h60, 16'h0004);
    avg(3, 0, 1'b0, 1'b0, 16'h9000);
    avg(3, 0, 1'b0, 1'b0, 16'h7E00);
    rd(7'h62, 16'h0008);
    rd(7'h61, 16'h0000);
    chk_reg(16'(expq.size()), 16'h0000);
    final_report;
  end
endmodule
